// file: core/sfcp_pkg.sv
// package: frame layout, crc and shared types of the spi frame crc port
// Behaviour
// - chip select high: clock and data ignored, serial output released.
// - chip select rising ends the frame and disables the port.
// - one input bit captured on each of the first 32 serial clock rising edges of a frame.
// - four command bits: status select for next frame or conversion start.
// - third and fourth command bits are reserved and do nothing.
// - three bit rolling count of conversion sets wraps after 111b.
// - format select zero: sixteen bit register value plus twelve status bits.
// - regular status order: crc, config lost, alerts, xyzt, error, selected.
// - error flag is or of all error bits; others copied directly.
// - lowest three status bits follow status select of previous frame.
// - format select nonzero: two channel results truncated to twelve bits.
// - special frame carries only four status bits.
// - special data returned on every frame until format select cleared.
// - four lowest bits of each frame both ways carry the crc.
// - crc polynomial x^4+x+1, register starts at all ones.
// - write executed only after incoming crc matches or with crc checking off, else discarded.
// - input crc error inverts last output crc bit, reported next frame; an error in the last input crc bit alone is only reported.
// - crc checking on at reset; bad commands ignored; magic word disables.
// - regular read returns addressed register in the same frame.
// - special frame replies ignore address and data fields of input; writes still use them.
// - regular write frame returns zeros in the data field.
// - output changes on falling edges, input sampled on rising edges.
`default_nettype none
package sfcp_pkg;
   localparam int          FRAME_BITS   = 32;
   localparam int          ADDR_BITS    = 7;
   localparam int          DATA_BITS    = 16;
   localparam int          CH_BITS      = 12;
   localparam logic [3:0]  CRC_INIT     = 4'hF;
   localparam logic [31:0] CRC_OFF_WORD = 32'h0F000407;
   localparam logic [5:0]  CNT_RW       = 6'h00;
   localparam logic [5:0]  CNT_ADDR     = 6'h07;
   localparam logic [5:0]  CNT_RDDATA   = 6'h0B;
   localparam logic [5:0]  CNT_LAST     = 6'h1F;
   localparam logic [5:0]  CNT_FULL     = 6'h20;
   localparam int          CMD_START    = 0;
   localparam int          CMD_SEL      = 1;

   typedef struct packed {
      logic                 rd;
      logic [ADDR_BITS-1:0] addr;
      logic [DATA_BITS-1:0] data;
      logic [3:0]           cmd;
      logic [3:0]           crc;
   } sfcp_frame_type;

   typedef struct packed {
      logic        special;
      logic        chk_en;
      logic [27:0] word;
   } sfcp_snap_type;

   function automatic logic [3:0] sfcp_crc4(input logic [27:0] frame);
      logic [31:0] padded;
      logic [3:0]  c;
      logic        inv;
      padded = {frame, 4'h0};
      c = CRC_INIT;
      for (int i = 31; i >= 0; i--) begin
         inv = padded[i] ^ c[3];
         c = {c[2], c[1], c[0] ^ inv, inv};
      end
      return c;
   endfunction
endpackage
`default_nettype wire

// file: core/sfcp_port.sv
// spi peripheral port with in-frame crc, regular and special frames
`default_nettype none
module sfcp_port
   import sfcp_pkg::*;
#(
   parameter int ERR_W = 8
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic                 ce,
   input  wire logic                 sck,
   input  wire logic                 cs_b,
   input  wire logic                 sdi,
   output var  logic                 sdo_out,
   output var  logic                 sdo_oe_b,
   output var  logic [ADDR_BITS-1:0] rd_addr,
   input  wire logic [DATA_BITS-1:0] rd_data,
   input  wire logic [2:0]           format_sel,
   input  wire logic                 cfg_lost,
   input  wire logic                 alert_state_hi,
   input  wire logic                 alert_state_lo,
   input  wire logic [3:0]           conversion_state,
   input  wire logic [2:0]           frontend_state,
   input  wire logic [ERR_W-1:0]     error_flags,
   input  wire logic                 conv_done,
   input  wire logic [DATA_BITS-1:0] ch1_result,
   input  wire logic [DATA_BITS-1:0] ch2_result,
   output var  logic                 wr_valid,
   output var  logic [ADDR_BITS-1:0] wr_addr,
   output var  logic [DATA_BITS-1:0] wr_data,
   output var  logic                 conv_start,
   output var  logic                 crc_check_en,
   output var  logic                 crc_error
);
   // ---------------- link domain (sck) ----------------
   logic                 link_rst_b;
   logic [5:0]           bit_cnt_reg;
   logic [30:0]          rx_shift_reg;
   logic                 rw_reg;
   logic [ADDR_BITS-1:0] rd_addr_reg;
   logic [DATA_BITS-1:0] rd_data_hold_reg;
   logic [31:0]          rx_word_reg;
   logic                 done_tgl_reg;
   logic                 sdo_reg;
   sfcp_snap_type        snap_reg;
   logic [27:0]          tx_body;
   logic [3:0]           tx_crc;
   logic [31:0]          tx_word;
   logic                 rx_part_err;
   logic [3:0]           rx_part_crc;
   logic                 sdo_live_reg;

   // chip select high holds the link logic in reset
   assign link_rst_b = rst_b & ~cs_b;

   // snap_reg is frozen by the clk side while a frame runs
   always_comb begin
      if (snap_reg.special) begin
         tx_body = snap_reg.word;
      end else if (rw_reg) begin
         tx_body = {snap_reg.word[27:16], rd_data_hold_reg};
      end else begin
         tx_body = {snap_reg.word[27:16], 16'h0000};
      end
      tx_crc = sfcp_crc4(tx_body);
      tx_word = {tx_body, tx_crc};
   end

   // last input crc bit is not in yet when the last output bit leaves
   assign rx_part_crc = sfcp_crc4(rx_shift_reg[30:3]);
   assign rx_part_err = rx_part_crc[3:1] != rx_shift_reg[2:0];

   always_ff @(posedge sck or negedge link_rst_b) begin
      if (!link_rst_b) begin
         bit_cnt_reg <= 6'h00;
         rx_shift_reg <= 31'h00000000;
      end else if (bit_cnt_reg != CNT_FULL) begin
         bit_cnt_reg <= bit_cnt_reg + 6'h01;
         rx_shift_reg <= {rx_shift_reg[29:0], sdi};
      end
   end

   always_ff @(posedge sck or negedge link_rst_b) begin
      if (!link_rst_b) begin
         rw_reg <= 1'b0;
         rd_addr_reg <= '0;
         rd_data_hold_reg <= '0;
      end else begin
         if (bit_cnt_reg == CNT_RW) begin
            rw_reg <= sdi;
         end
         if (bit_cnt_reg == CNT_ADDR) begin
            rd_addr_reg <= {rx_shift_reg[5:0], sdi};
         end
         if (bit_cnt_reg == CNT_RDDATA) begin
            rd_data_hold_reg <= rd_data;
         end
      end
   end

   // word and toggle survive chip select so the clk side can read them
   always_ff @(posedge sck or negedge rst_b) begin
      if (!rst_b) begin
         rx_word_reg <= 32'h00000000;
         done_tgl_reg <= 1'b0;
      end else if (bit_cnt_reg == CNT_LAST) begin
         rx_word_reg <= {rx_shift_reg, sdi};
         done_tgl_reg <= ~done_tgl_reg;
      end
   end

   always_ff @(negedge sck or negedge link_rst_b) begin
      if (!link_rst_b) begin
         sdo_reg <= 1'b0;
      end else if (bit_cnt_reg == CNT_LAST) begin
         sdo_reg <= tx_crc[0] ^ (snap_reg.chk_en & rx_part_err);
      end else if (bit_cnt_reg != CNT_FULL) begin
         sdo_reg <= tx_word[~bit_cnt_reg[4:0]];
      end
   end

   // first bit stands until the first falling edge, not only until rise one
   always_ff @(negedge sck or negedge link_rst_b) begin
      if (!link_rst_b) begin
         sdo_live_reg <= 1'b0;
      end else begin
         sdo_live_reg <= 1'b1;
      end
   end

   assign sdo_out = sdo_live_reg ? sdo_reg : tx_word[31];
   assign sdo_oe_b = cs_b;
   assign rd_addr = rd_addr_reg;

   // ---------------- system domain (clk) ----------------
   logic           cs_s1_reg;
   logic           cs_s2_reg;
   logic           tg_s1_reg;
   logic           tg_s2_reg;
   logic           tg_s3_reg;
   logic           frame_pulse;
   sfcp_frame_type rx;
   logic           crc_ok;
   logic           accept;
   logic           crc_en_reg;
   logic           prev_crc_err_reg;
   logic           status_sel_reg;
   logic [2:0]     set_count_reg;
   logic [2:0]     sel_bits;
   logic           error_stat;
   logic           wr_valid_reg;
   logic [ADDR_BITS-1:0] wr_addr_reg;
   logic [DATA_BITS-1:0] wr_data_reg;
   logic           conv_start_reg;
   logic           crc_error_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         tg_s1_reg <= 1'b0;
         tg_s2_reg <= 1'b0;
         tg_s3_reg <= 1'b0;
      end else if (ce) begin
         cs_s1_reg <= cs_b;
         cs_s2_reg <= cs_s1_reg;
         tg_s1_reg <= done_tgl_reg;
         tg_s2_reg <= tg_s1_reg;
         tg_s3_reg <= tg_s2_reg;
      end
   end

   assign frame_pulse = ce & (tg_s2_reg ^ tg_s3_reg);
   assign rx = sfcp_frame_type'(rx_word_reg);
   assign crc_ok = sfcp_crc4(rx_word_reg[31:4]) == rx.crc;
   assign accept = crc_ok | ~crc_en_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         crc_en_reg <= 1'b1;
         prev_crc_err_reg <= 1'b0;
         status_sel_reg <= 1'b0;
      end else if (frame_pulse) begin
         prev_crc_err_reg <= crc_en_reg & ~crc_ok;
         if (rx_word_reg == CRC_OFF_WORD) begin
            crc_en_reg <= 1'b0;
         end
         if (accept) begin
            status_sel_reg <= rx.cmd[CMD_SEL];
         end
      end
   end

   // reserved command bits two and three are never looked at
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_valid_reg <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
         conv_start_reg <= 1'b0;
         crc_error_reg <= 1'b0;
      end else if (ce) begin
         wr_valid_reg <= frame_pulse & accept & ~rx.rd;
         conv_start_reg <= frame_pulse & accept & rx.cmd[CMD_START];
         crc_error_reg <= frame_pulse & ~crc_ok;
         if (frame_pulse & accept & ~rx.rd) begin
            wr_addr_reg <= rx.addr;
            wr_data_reg <= rx.data;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         set_count_reg <= 3'h0;
      end else if (ce && conv_done) begin
         set_count_reg <= set_count_reg + 3'h1;
      end
   end

   assign error_stat = |error_flags;
   assign sel_bits = status_sel_reg ? set_count_reg : frontend_state;

   // refreshed only while idle, so the link reads a steady word
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         snap_reg <= '0;
      end else if (ce && cs_s2_reg) begin
         snap_reg.special <= format_sel != 3'h0;
         snap_reg.chk_en <= crc_en_reg;
         if (format_sel != 3'h0) begin
            snap_reg.word <= {error_stat, sel_bits,
                              ch1_result[15:4],
                              ch2_result[15:4]};
         end else begin
            snap_reg.word <= {prev_crc_err_reg, cfg_lost,
                              alert_state_hi, alert_state_lo,
                              conversion_state, error_stat,
                              sel_bits, 16'h0000};
         end
      end
   end

   assign wr_valid = wr_valid_reg;
   assign wr_addr = wr_addr_reg;
   assign wr_data = wr_data_reg;
   assign conv_start = conv_start_reg;
   assign crc_check_en = crc_en_reg;
   assign crc_error = crc_error_reg;

   // ---------------- checks ----------------
   chk_write_discard: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_pulse && crc_en_reg && !crc_ok |=> !wr_valid_reg)
      else $error("write taken despite crc error");

   chk_write_issue: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_pulse && accept && !rx.rd |=>
      wr_valid_reg && wr_addr_reg == $past(rx.addr)
      ##1 !wr_valid_reg)
      else $error("write not issued once");

   chk_conv_start: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_pulse && !accept |=> !conv_start_reg)
      else $error("conversion started by bad frame");

   chk_count_wrap: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && conv_done && set_count_reg == 3'h7 |=>
      set_count_reg == 3'h0)
      else $error("set count did not wrap");

   chk_crc_disable: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_pulse && rx_word_reg == CRC_OFF_WORD |=>
      !crc_en_reg ##1 !crc_en_reg)
      else $error("crc check not disabled");

   chk_prev_crc: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_pulse && crc_en_reg && !crc_ok |=> prev_crc_err_reg)
      else $error("previous crc error not flagged");

   chk_snap_freeze: assert property (
      @(posedge clk) disable iff (!rst_b)
      !cs_s2_reg && !cs_s1_reg |=> $stable(snap_reg))
      else $error("snapshot changed during frame");

   chk_snap_special: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && cs_s2_reg && format_sel != 3'h0 |=>
      snap_reg.special && snap_reg.word[11:0] == $past(ch2_result[15:4]))
      else $error("special frame not prepared");

   chk_write_zero: assert property (
      @(negedge sck) disable iff (!link_rst_b)
      !snap_reg.special && !rw_reg && bit_cnt_reg > 6'h00 |->
      tx_word[19:4] == 16'h0000)
      else $error("write frame data not zero");

   chk_addr_latch: assert property (
      @(posedge sck) disable iff (!link_rst_b)
      bit_cnt_reg == CNT_ADDR |=>
      rd_addr_reg == rx_shift_reg[6:0] && bit_cnt_reg == 6'h08)
      else $error("read address not latched");

   chk_sdo_order: assert property (
      @(posedge sck) disable iff (!link_rst_b)
      bit_cnt_reg < CNT_LAST |-> sdo_out == tx_word[~bit_cnt_reg[4:0]])
      else $error("serial output bit out of order");

   chk_sdo_last: assert property (
      @(posedge sck) disable iff (!link_rst_b)
      bit_cnt_reg == CNT_LAST && !snap_reg.chk_en |->
      sdo_out == tx_word[0])
      else $error("last crc bit flipped with checking off");

   chk_conv_issue: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_pulse && accept && rx.cmd[CMD_START] |=>
      conv_start_reg ##1 !conv_start_reg)
      else $error("conversion start not pulsed once");

   chk_crc_flag: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_pulse && !crc_ok |=> crc_error_reg ##1 !crc_error_reg)
      else $error("crc error not pulsed once");

   chk_sel_hold: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_pulse && !accept |=>
      $stable(status_sel_reg) && $stable(wr_data_reg))
      else $error("refused frame changed state");

   chk_status_order: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && cs_s2_reg && format_sel == 3'h0 |=>
      snap_reg.word[27] == $past(prev_crc_err_reg) &&
      snap_reg.word[19] == $past(|error_flags))
      else $error("regular status word misordered");
endmodule // sfcp_port
`default_nettype wire

// file: tb/sfcp_ctrl.sv
// spi controller model that runs one framed transfer per call
`default_nettype none
module sfcp_ctrl (
   output var  logic sck,
   output var  logic cs_b,
   output var  logic sdi,
   input  wire logic sdo
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sck = 1'b0;
      cs_b = 1'b1;
      sdi = 1'b0;
   end
   // serial clock stands still outside frames; n below 32 aborts early
   task automatic xfer(input logic [31:0] w, input int n,
                       output logic [31:0] r);
      r = 32'h0;
      cs_b = 1'b0;
      sdi = w[31];
      #400;
      for (int i = 0; i < n; i++) begin
         sdi = w[31-i];
         // sampled just before the rise, clear of the falling-edge update
         #3 r = {r[30:0], sdo};
         sck = 1'b1;
         #3 sck = 1'b0;
      end
      #3 cs_b = 1'b1;
      sdi = ~sdi; // line inverted after the frame shows no stale value
      #1500;
   endtask
endmodule // sfcp_ctrl
`default_nettype wire

// file: tb/sfcp_port_bench.sv
// self-checking bench of the spi frame crc port
`default_nettype none
module sfcp_port_bench
   import sfcp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_b, ce, cfg_lost, alert_state_hi, alert_state_lo;
   logic        conv_done;
   logic [3:0]  conversion_state;
   logic [2:0]  frontend_state, format_sel;
   logic [7:0]  error_flags;
   logic [15:0] ch1_result, ch2_result, rd_data;
   wire         sck, cs_b, sdi, sdo, sdo_out, sdo_oe_b, wr_valid;
   wire         conv_start, crc_check_en, crc_error;
   wire  [6:0]  rd_addr, wr_addr;
   wire  [15:0] wr_data;
   int          errors = 0, check_count = 0, n_wr = 0, n_cs = 0, n_ce = 0;

   assign sdo = sdo_oe_b ? 1'bz : sdo_out;
   // register file stand-in: value derived from the address
   assign rd_data = {rd_addr, 9'h0A5};

   sfcp_ctrl ctl (.sck(sck), .cs_b(cs_b), .sdi(sdi), .sdo(sdo));
   sfcp_port dut (.clk(clk), .rst_b(rst_b), .ce(ce), .sck(sck),
      .cs_b(cs_b), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b),
      .rd_addr(rd_addr), .rd_data(rd_data), .format_sel(format_sel),
      .cfg_lost(cfg_lost), .alert_state_hi(alert_state_hi),
      .alert_state_lo(alert_state_lo), .conversion_state(conversion_state),
      .frontend_state(frontend_state), .error_flags(error_flags),
      .conv_done(conv_done), .ch1_result(ch1_result),
      .ch2_result(ch2_result), .wr_valid(wr_valid), .wr_addr(wr_addr),
      .wr_data(wr_data), .conv_start(conv_start),
      .crc_check_en(crc_check_en), .crc_error(crc_error));

   always_ff @(posedge clk) begin
      n_wr <= n_wr + int'(wr_valid);
      n_cs <= n_cs + int'(conv_start);
      n_ce <= n_ce + int'(crc_error);
   end

   function automatic logic [3:0] crc(input logic [27:0] f);
      logic [31:0] p;
      logic [3:0]  c;
      logic        v;
      p = {f, 4'h0};
      c = 4'hF;
      for (int i = 31; i >= 0; i--) begin
         v = p[i] ^ c[3];
         c = {c[2:1], c[0] ^ v, v};
      end
      return c;
   endfunction

   function automatic logic [31:0] mk(input logic [27:0] x);
      return {x, crc(x)};
   endfunction

   function automatic logic [11:0] st(input int p, input logic [2:0] s);
      return {p[0], cfg_lost, alert_state_hi, alert_state_lo,
              conversion_state, |error_flags, s};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one full frame, answer compared with last crc bit optionally flipped
   task automatic frame(input logic [31:0] w, input logic [27:0] x,
                        input int b);
      logic [31:0] r;
      ctl.xfer(w, 32, r);
      check(r, mk(x) ^ {31'h0, b[0]});
   endtask

   task automatic t_regular;
      check({31'h0, sdo_oe_b}, 32'h1);
      check({31'h0, crc_check_en}, 32'h1);
      frame(mk({1'b1, 7'h09, 16'h0, 4'h0}), {st(0, 3'h5), 16'h12A5}, 0);
      frame(mk({1'b0, 7'h12, 16'hBEEF, 4'h3}), {st(0, 3'h5), 16'h0}, 0);
      check({9'h0, wr_addr, wr_data}, {9'h0, 7'h12, 16'hBEEF});
      check(n_wr + (n_cs << 8), 32'h101);
   endtask

   task automatic t_count;
      repeat (9) begin
         @(posedge clk) conv_done <= 1'b1;
         @(posedge clk) conv_done <= 1'b0;
      end
      repeat (3) @(posedge clk);
      frame(mk({1'b1, 7'h09, 16'h0, 4'h0}), {st(0, 3'h1), 16'h12A5}, 0);
   endtask

   task automatic t_badcrc;
      frame(mk({1'b0, 7'h33, 16'h1111, 4'h3}) ^ 32'h8,
            {st(0, 3'h5), 16'h0}, 1);
      check(n_wr + (n_cs << 8) + (n_ce << 16), 32'h10101);
      frame(mk({1'b1, 7'h09, 16'h0, 4'hC}), {st(1, 3'h5), 16'h12A5}, 0);
      check(n_cs, 32'h1);
   endtask

   task automatic t_special;
      @(posedge clk);
      format_sel <= 3'h2;
      error_flags <= 8'h10;
      repeat (3) @(posedge clk);
      frame(mk({1'b1, 7'h09, 16'hFFFF, 4'h0}),
            {4'hD, 12'hABC, 12'h135}, 0);
      frame(mk({1'b0, 7'h20, 16'h5A5A, 4'h0}),
            {4'hD, 12'hABC, 12'h135}, 0);
      check({16'h0, wr_data}, 32'h5A5A);
      @(posedge clk);
      format_sel <= 3'h0;
      error_flags <= 8'h00;
      repeat (3) @(posedge clk);
      frame(mk({1'b1, 7'h09, 16'h0, 4'h0}), {st(0, 3'h5), 16'h12A5}, 0);
   endtask

   task automatic t_disable;
      logic [31:0] r;
      frame(CRC_OFF_WORD, {st(0, 3'h5), 16'h0}, 0);
      check({crc_check_en, wr_addr, wr_data}, {9'h00F, 16'h0004});
      frame(mk({1'b0, 7'h44, 16'h2222, 4'h0}) ^ 32'h8,
            {st(0, 3'h5), 16'h0}, 0);
      check({16'h0, wr_data}, 32'h2222);
      ctl.xfer(mk({1'b0, 7'h55, 16'h3333, 4'h1}), 20, r);
      check(n_wr + (n_cs << 8) + (n_ce << 16), 32'h20104);
      check({31'h0, sdo_oe_b}, 32'h1);
   endtask

   task automatic final_report;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #100000;
      errors++;
      final_report;
   end

   initial begin
      {rst_b, conv_done, format_sel} = 5'h00;
      {ce, cfg_lost, alert_state_hi, alert_state_lo} = 4'hD;
      {conversion_state, frontend_state, error_flags} = 15'h2D00;
      {ch1_result, ch2_result} = 32'hABCD_1357;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_regular;
      t_count;
      t_badcrc;
      t_special;
      t_disable;
      final_report;
   end
endmodule // sfcp_port_bench
`default_nettype wire
